// >>> hdl/cmpev_pkg.sv
// Package of register map, field layout and types of the comparator event block
package cmpev_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h08;
  localparam logic [7:0] CMP_STATUS_OFFSET = 8'h0c;
  localparam int EVENT_POLARITY_SELECT_LSB = 6;
  localparam int EVFLAG_BIT = 9;
  localparam int INVERT_BIT = 13;
  localparam int REFSEL_BIT = 4;
  localparam int CHSEL_LSB = 0;
  localparam int CMPOUT_BIT = 8;
  localparam int REFCHOICE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_22d3;
  localparam logic [1:0] POL_ANY = 2'h3;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_OFF = 2'h0;

  typedef enum logic [3:0] {
    CMPEV_INV_PIN_B = 4'h1,
    CMPEV_INV_PIN_C = 4'h2,
    CMPEV_INV_PIN_D = 4'h4,
    CMPEV_INV_BANDGAP = 4'h8
  } cmpev_inv_route_t;

  typedef struct packed {
    logic noninv_pin_a;
    logic noninv_internal_ref;
    logic internal_reference_choice;
    cmpev_inv_route_t inv_route;
  } cmpev_route_t;
endpackage

// >>> hdl/cmpev_top.sv
// Comparator event selection, input routing and Wishbone register slave
// How it works
// (RULE1) Polarity 11: event on any output change while event flag clear
// (RULE2) Polarity 10: falling edge, or rising edge with inversion on
// (RULE3) Polarity 01: rising edge, or falling edge with inversion on
// (RULE4) Polarity 00: no event is ever produced
// (RULE5) Reference bit picks internal reference when set, else pin A
// (RULE6) Channel code picks inverting input: 11 band gap, 10 D, 01 C, 00 B
// (RULE7) Control bits 5 and 3 to 2 are not implemented and read zero
// (RULE8) Event flag sets on each qualifying event and stays until cleared
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmpev_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator core
  input wire logic cmp_out_i,
  output cmpev_pkg::cmpev_route_t route_o,
  // Requests
  output logic event_o,
  output logic irq_o
);
  logic [1:0] sync_q, sync_d;
  logic prev_q, prev_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic refch_q, refch_d;
  logic ist_q, ist_d;
  logic imask_q, imask_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic event_q, event_d;
  cmpev_pkg::cmpev_route_t route_q, route_d;
  logic [1:0] pol;
  logic inv, out_now, rise, fall, hit, req, wr;
  logic [31:0] wmask, ctrl_rd;

  assign pol = ctrl_q[cmpev_pkg::EVENT_POLARITY_SELECT_LSB +: 2];
  assign inv = ctrl_q[cmpev_pkg::INVERT_BIT];
  assign out_now = sync_q[1] ^ inv;
  assign rise = out_now & ~prev_q;
  assign fall = ~out_now & prev_q;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    ctrl_rd = ctrl_q & cmpev_pkg::CTRL_WMASK; // RULE7
    ctrl_rd[cmpev_pkg::CMPOUT_BIT] = out_now;
  end

  always_comb begin
    unique case (pol)
      cmpev_pkg::POL_ANY: hit = (rise | fall) &
        ~ctrl_q[cmpev_pkg::EVFLAG_BIT]; // RULE1
      cmpev_pkg::POL_FALL: hit = inv ? rise : fall; // RULE2
      cmpev_pkg::POL_RISE: hit = inv ? fall : rise; // RULE3
      default: hit = 1'b0; // RULE4
    endcase
  end

  always_comb begin
    sync_d = {sync_q[0], cmp_out_i};
    prev_d = out_now;
    event_d = hit;
    ack_d = req;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    refch_d = refch_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (wr && wb_adr_i == cmpev_pkg::CTRL_OFFSET) begin
      ctrl_d = (ctrl_q & ~(wmask & cmpev_pkg::CTRL_WMASK)) |
               (wb_dat_i & wmask & cmpev_pkg::CTRL_WMASK);
    end
    if (wr && wb_adr_i == cmpev_pkg::CMP_STATUS_OFFSET && wb_sel_i[0]) begin
      refch_d = wb_dat_i[cmpev_pkg::REFCHOICE_BIT];
    end
    if (wr && wb_adr_i == cmpev_pkg::INT_MASK_OFFSET && wb_sel_i[0]) begin
      imask_d = wb_dat_i[0];
    end
    if (wr && wb_adr_i == cmpev_pkg::INT_STATUS_OFFSET && wb_sel_i[0] &&
        wb_dat_i[0]) begin
      ist_d = 1'b0;
    end
    if (hit) begin
      ctrl_d[cmpev_pkg::EVFLAG_BIT] = 1'b1; // RULE8
      ist_d = 1'b1;
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        cmpev_pkg::CTRL_OFFSET: rdat_d = ctrl_rd;
        cmpev_pkg::INT_STATUS_OFFSET: rdat_d = {31'h0, ist_q};
        cmpev_pkg::INT_MASK_OFFSET: rdat_d = {31'h0, imask_q};
        cmpev_pkg::CMP_STATUS_OFFSET: rdat_d = {31'h0, refch_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    route_d.noninv_internal_ref = ctrl_q[cmpev_pkg::REFSEL_BIT]; // RULE5
    route_d.noninv_pin_a = ~ctrl_q[cmpev_pkg::REFSEL_BIT]; // RULE5
    route_d.internal_reference_choice = refch_q;
    unique case (ctrl_q[cmpev_pkg::CHSEL_LSB +: 2])
      2'h3: route_d.inv_route = cmpev_pkg::CMPEV_INV_BANDGAP; // RULE6
      2'h2: route_d.inv_route = cmpev_pkg::CMPEV_INV_PIN_D; // RULE6
      2'h1: route_d.inv_route = cmpev_pkg::CMPEV_INV_PIN_C; // RULE6
      default: route_d.inv_route = cmpev_pkg::CMPEV_INV_PIN_B; // RULE6
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync_q <= 2'h0;
      prev_q <= 1'b0;
      ctrl_q <= cmpev_pkg::CTRL_RESET;
      refch_q <= 1'b0;
      ist_q <= 1'b0;
      imask_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      event_q <= 1'b0;
      route_q <= '{noninv_pin_a: 1'b1, noninv_internal_ref: 1'b0,
                   internal_reference_choice: 1'b0,
                   inv_route: cmpev_pkg::CMPEV_INV_PIN_B};
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      ctrl_q <= ctrl_d;
      refch_q <= refch_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      event_q <= event_d;
      route_q <= route_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign event_o = event_q;
  assign irq_o = ist_q & imask_q;
  assign route_o = route_q;

  // Assertion clock and reset
  default clocking asrt_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Qualifying edges per polarity mode
  sequence rise_seen_s;
    pol == cmpev_pkg::POL_RISE && !inv && rise;
  endsequence
  sequence fall_seen_s;
    pol == cmpev_pkg::POL_FALL && !inv && fall;
  endsequence
  sequence inv_rise_seen_s;
    pol == cmpev_pkg::POL_RISE && inv && fall;
  endsequence
  sequence inv_fall_seen_s;
    pol == cmpev_pkg::POL_FALL && inv && rise;
  endsequence
  sequence any_seen_s;
    pol == cmpev_pkg::POL_ANY && (rise || fall) &&
    !ctrl_q[cmpev_pkg::EVFLAG_BIT];
  endsequence

  // Bus request and its one-cycle answer
  sequence wb_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // Event generation
  rise_event_a: assert property ( // RULE3
    rise_seen_s |=> event_o && ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("rising edge gave no event");
  fall_event_a: assert property ( // RULE2
    fall_seen_s |=> event_o)
    else $error("falling edge gave no event");
  inv_rise_event_a: assert property ( // RULE3
    inv_rise_seen_s |=> event_o)
    else $error("inverted rise mode missed an event");
  inv_fall_event_a: assert property ( // RULE2
    inv_fall_seen_s |=> event_o)
    else $error("inverted fall mode missed an event");
  inv_fall_a: assert property ( // RULE2
    (pol == cmpev_pkg::POL_FALL && inv && fall) |=> !event_o)
    else $error("inverted falling edge gave an event");
  rise_quiet_a: assert property ( // RULE3
    (pol == cmpev_pkg::POL_RISE && !inv && fall) |=> !event_o)
    else $error("falling edge gave an event in rise mode");
  any_change_a: assert property ( // RULE1
    (pol == cmpev_pkg::POL_ANY && $changed(out_now) &&
     !ctrl_q[cmpev_pkg::EVFLAG_BIT] && $past(pol) == cmpev_pkg::POL_ANY &&
     $stable(inv)) |=> event_o)
    else $error("change missed in any-change mode");
  any_event_a: assert property ( // RULE1
    any_seen_s |=> event_o && ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("any-change event not flagged");
  any_blocked_a: assert property ( // RULE1
    (pol == cmpev_pkg::POL_ANY && ctrl_q[cmpev_pkg::EVFLAG_BIT]) |=> !event_o)
    else $error("event while flag set");
  off_quiet_a: assert property ( // RULE4
    pol == cmpev_pkg::POL_OFF |=> !event_o)
    else $error("event while disabled");
  event_flag_a: assert property ( // RULE8
    event_o |-> ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("event without flag");

  // Sticky flags and interrupt mask
  flag_sticky_a: assert property ( // RULE8
    (ctrl_q[cmpev_pkg::EVFLAG_BIT] && !(wr && wb_adr_i == 8'h00 &&
     wb_sel_i[1])) |=> ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("event flag dropped by itself");
  flag_set_wins_a: assert property ( // RULE8
    hit |=> ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("event flag not set by event");
  flag_clear_a: assert property ( // RULE8
    (wr && wb_adr_i == cmpev_pkg::CTRL_OFFSET && wb_sel_i[1] &&
     !wb_dat_i[cmpev_pkg::EVFLAG_BIT] && !hit) |=>
    !ctrl_q[cmpev_pkg::EVFLAG_BIT])
    else $error("event flag not cleared by software");
  ist_set_wins_a: assert property (
    hit |=> ist_q)
    else $error("interrupt status not set by event");
  ist_clear_a: assert property (
    (wr && wb_adr_i == cmpev_pkg::INT_STATUS_OFFSET && wb_sel_i[0] &&
     wb_dat_i[0] && !hit) |=> !ist_q)
    else $error("interrupt status not cleared");
  mask_write_a: assert property (
    (wr && wb_adr_i == cmpev_pkg::INT_MASK_OFFSET && wb_sel_i[0]) |=>
    imask_q == $past(wb_dat_i[0]))
    else $error("interrupt mask write lost");

  // Input routing
  ref_route_a: assert property ( // RULE5
    ##1 route_o.noninv_internal_ref == $past(ctrl_q[cmpev_pkg::REFSEL_BIT]) &&
    route_o.noninv_pin_a != route_o.noninv_internal_ref)
    else $error("reference routing wrong");
  pin_a_route_a: assert property ( // RULE5
    ##1 route_o.noninv_pin_a == !$past(ctrl_q[cmpev_pkg::REFSEL_BIT]))
    else $error("pin a routing wrong");
  ref_choice_a: assert property ( // RULE5
    ##1 route_o.internal_reference_choice == $past(refch_q))
    else $error("reference choice routing wrong");
  ch_route_a: assert property ( // RULE6
    ##1 ($past(ctrl_q[1:0]) == 2'h3) ==
    (route_o.inv_route == cmpev_pkg::CMPEV_INV_BANDGAP))
    else $error("band gap routing wrong");
  pin_d_route_a: assert property ( // RULE6
    ##1 ($past(ctrl_q[1:0]) == 2'h2) ==
    (route_o.inv_route == cmpev_pkg::CMPEV_INV_PIN_D))
    else $error("pin d routing wrong");
  pin_c_route_a: assert property ( // RULE6
    ##1 ($past(ctrl_q[1:0]) == 2'h1) ==
    (route_o.inv_route == cmpev_pkg::CMPEV_INV_PIN_C))
    else $error("pin c routing wrong");
  pin_b_route_a: assert property ( // RULE6
    ##1 ($past(ctrl_q[1:0]) == 2'h0) ==
    (route_o.inv_route == cmpev_pkg::CMPEV_INV_PIN_B))
    else $error("pin b routing wrong");

  // Unimplemented control bits
  unimpl_zero_a: assert property ( // RULE7
    wb_ack_o && $past(wb_adr_i) == 8'h00 && !$past(wb_we_i) |->
    wb_dat_o[5] == 1'b0 && wb_dat_o[3:2] == 2'h0)
    else $error("unimplemented bits read nonzero");
  unimpl_hold_a: assert property ( // RULE7
    ctrl_q[5] == 1'b0 && ctrl_q[3:2] == 2'h0)
    else $error("unimplemented bits stored");

  // Bus handshake and read data
  ack_answer_a: assert property (
    wb_take_s |=> wb_answer_s)
    else $error("request not answered by one ack");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  mask_read_a: assert property (
    (wb_ack_o && $past(wb_adr_i) == cmpev_pkg::INT_MASK_OFFSET &&
     !$past(wb_we_i)) |-> wb_dat_o == {31'h0, $past(imask_q)})
    else $error("mask read data wrong");
  status_read_a: assert property (
    (wb_ack_o && $past(wb_adr_i) == cmpev_pkg::INT_STATUS_OFFSET &&
     !$past(wb_we_i)) |-> wb_dat_o == {31'h0, $past(ist_q)})
    else $error("status read data wrong");

  // Comparator input synchroniser
  sync_delay_a: assert property (
    ##2 sync_q[1] == $past(cmp_out_i, 2))
    else $error("comparator input delay wrong");
endmodule
`default_nettype wire

// >>> verif/cmpev_core_model.sv
// Behavioural model of the comparator core and its input pins
`timescale 1ns/1ps
`default_nettype none
module cmpev_core_model (
  // Routing from the block
  input wire cmpev_pkg::cmpev_route_t route_i,
  // Pin levels a, b, c, d and internal reference
  input wire logic [3:0] pin_i,
  input wire logic vref_i,
  // Comparator output
  output logic cmp_o
);
  logic pos;
  logic neg;
  assign pos = route_i.noninv_pin_a ? pin_i[0] : vref_i;
  assign neg = |({1'b0, pin_i[3:1]} & route_i.inv_route);
  assign cmp_o = pos & ~neg;
endmodule
`default_nettype wire

// >>> verif/cmpev_top_bench.sv
// Self-checking bench of the comparator event block
`timescale 1ns/1ps
`default_nettype none
module cmpev_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic ack, cmp, ev, irq;
  logic [3:0] pins = 4'h0;
  cmpev_pkg::cmpev_route_t route;
  int failures = 0;
  int num_checks = 0;
  int evs = 0;
  int mark = 0;
  always #20 clk = ~clk;
  cmpev_top dut (.sys_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_out_i(cmp),
    .route_o(route), .event_o(ev), .irq_o(irq));
  cmpev_core_model model (.route_i(route), .pin_i(pins), .vref_i(1'b1),
    .cmp_o(cmp));
  always @(posedge clk) if (ev === 1'b1) evs <= evs + 1;
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stop_test;
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic edge_case(input logic [1:0] p, input logic inv,
                           input logic up, input logic e);
    pins[0] <= ~up;
    bus(1'b1, 8'h00, {18'h0, inv, 5'h0, p, 6'h0});
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h00, {18'h0, inv, 5'h0, p, 6'h0});
    bus(1'b1, 8'h04, 32'h0000_0001);
    mark = evs;
    pins[0] <= up;
    repeat (6) @(posedge clk);
    chk("events", {31'h0, e}, 32'(evs - mark));
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("flag", {31'h0, e}, {31'h0, rd[9]});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    bus(1'b1, 8'h00, 32'h0000_002c);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl loose bits", 32'h0000_0000, rd);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h00, 32'(c));
      chk("inv route", 32'(1 << c), {28'h0, route.inv_route});
    end
    bus(1'b1, 8'h0c, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_0010);
    chk("noninv ref", 32'h0000_0003, {29'h0, route[6:4]});
    bus(1'b1, 8'h00, 32'h0000_0000);
    chk("noninv pin", 32'h0000_0005, {29'h0, route[6:4]});
    edge_case(2'h3, 1'b0, 1'b1, 1'b1);
    mark = evs;
    pins[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("flag held", 32'h0000_0000, 32'(evs - mark));
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    bus(1'b1, 8'h08, 32'h0000_0001);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    bus(1'b1, 8'h04, 32'h0000_0001);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
    edge_case(2'h3, 1'b0, 1'b0, 1'b1);
    edge_case(2'h2, 1'b0, 1'b0, 1'b1);
    edge_case(2'h2, 1'b0, 1'b1, 1'b0);
    edge_case(2'h2, 1'b1, 1'b0, 1'b1);
    edge_case(2'h1, 1'b0, 1'b1, 1'b1);
    edge_case(2'h1, 1'b0, 1'b0, 1'b0);
    edge_case(2'h1, 1'b1, 1'b1, 1'b1);
    edge_case(2'h0, 1'b0, 1'b1, 1'b0);
    edge_case(2'h0, 1'b1, 1'b0, 1'b0);
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
